/* File: rtc_port_params.svh */
`ifndef RTC_PORT_PARAMS_SVH
`define RTC_PORT_PARAMS_SVH

// Clock and timebase
`define CLK_HZ            20000000
`define OSC_HZ            32768
`define OSC_DIV_CYCLES    (`CLK_HZ / `OSC_HZ)
`define OSC_DIV_W         10
`define CHAIN_W           15

// Byte locations
`define LOC_COUNT         128
`define LOC_SECONDS       7'h00
`define LOC_REG_A         7'h0A
`define LOC_REG_B         7'h0B
`define LOC_REG_C         7'h0C
`define LOC_REG_D         7'h0D
`define LOC_CENTURY       7'h32

// Control byte A fields
`define A_UIP             7
`define A_DV_HI           6
`define A_DV_LO           4
`define A_RS_HI           3
`define A_RS_LO           0
`define DV_RUN            3'h2
`define DV_CHAIN_HOLD     2'h3
`define DV_RST            3'h0
`define RS_RST            4'h0
`define RS_OFF            4'h0
`define RS_TAP_1          4'h1
`define RS_TAP_2          4'h2
`define TAP_IDX_1         4'h6
`define TAP_IDX_2         4'h7
`define TAP_IDX_OFFSET    4'h2

// Control byte B fields
`define B_SET             7
`define B_PIE             6
`define B_AIE             5
`define B_UIE             4
`define B_SQUARE_WAVE_ENABLE            3
`define B_DM              2
`define B_HR24            1
`define B_DSE             0
`define REG_B_RST         8'h00

// Flag byte C and status byte D fields
`define C_SUMMARY_INT_FLAG            7
`define C_PF              6
`define C_AF              5
`define C_UF              4
`define D_VRT             7

// Seconds byte top bit is read-only
`define SEC_WR_MASK       8'h7F
`define BYTE_ZERO         8'h00

`endif

/* File: rtc_port_pkg.sv */
package rtc_port_pkg;

  typedef logic [7:0] byte_type;
  typedef logic [6:0] loc_type;

  typedef enum logic {
    STYLE_RW_STROBES  = 1'b0,
    STYLE_DATA_STROBE = 1'b1
  } bus_style_type;

  typedef enum logic [2:0] {
    PH_IDLE  = 3'b001,
    PH_READ  = 3'b010,
    PH_WRITE = 3'b100
  } bus_phase_type;

endpackage : rtc_port_pkg

/* File: strobe_if.sv */
`timescale 1ns/1ps
interface strobe_if;
  logic level;
  logic rise;
  logic fall;

  modport producer (output level, output rise, output fall);
  modport consumer (input level, input rise, input fall);
endinterface : strobe_if

/* File: strobe_sync.sv */
`timescale 1ns/1ps
module strobe_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Raw pin
  input  wire logic pin,
  // Synchronised level and edges
  strobe_if.producer sp
);

  logic meta;
  logic stable;
  logic prev;

  // Two flops, then a third for edge detection [RQ25]
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta   <= 1'b0;
      stable <= 1'b0;
      prev   <= 1'b0;
    end else begin
      meta   <= pin;
      stable <= meta;
      prev   <= stable;
    end
  end

  assign sp.level = stable;
  assign sp.rise  = stable & ~prev;
  assign sp.fall  = ~stable & prev;

endmodule : strobe_sync

/* File: rtc_muxed_host_bus_port.sv */
`timescale 1ns/1ps
`include "rtc_port_params.svh"
// Summary of operation
// RQ1: Style pin low: read/write strobes; high: data strobe
// RQ2: Address strobe fall latches seven address bits
// RQ3: Address strobe rise discards address regardless of select
// RQ4: Host presents address before address strobe falls
// RQ5: Read drives eight bits late in strobe pulse
// RQ6: Bus released on data strobe fall or read rise
// RQ7: Host holds write data stable late in pulse
// RQ8: Data strobe style captures write on falling edge
// RQ9: Direction high marks read, low marks write
// RQ10: Strobe style: direction is write enable, read enables
// RQ11: Without chip select, addresses latch, no access
// RQ12: Host holds chip select across all strobes
// RQ13: Power fail forces chip select inactive
// RQ14: Interrupt pin low while enabled flag set
// RQ15: Reading flag byte clears flags, releases interrupt
// RQ16: Reset pin clears interrupt and square-wave enables
// RQ17: Reset pin clears all flags, releases interrupt
// RQ18: Bus accesses refused while reset pin low
// RQ19: Reset pin leaves counters, calendar, RAM unchanged
// RQ20: Host holds power-up reset beyond internal timer
// RQ21: Square wave picks one of thirteen divider taps
// RQ22: 128 locations, century byte at 32h
// RQ23: Flag byte and status byte are read-only
// RQ24: Rate select read/write, kept through reset pin
// RQ25: Strobes synchronised before their edges are used
// RQ26: Flags clear only after the read completes
module rtc_muxed_host_bus_port (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  // Multiplexed host bus
  input  wire logic                     bus_style_select,
  input  wire logic                     address_latch_strobe,
  input  wire logic                     data_strobe_pin,
  input  wire logic                     rw_pin,
  input  wire logic                     chip_select_n,
  input  wire rtc_port_pkg::byte_type   muxed_bus_lines_in,
  output      rtc_port_pkg::byte_type   muxed_bus_lines_out,
  output wire logic                     muxed_bus_lines_oe_n,
  // Device reset and supply
  input  wire logic                     reset_pin_n,
  input  wire logic                     power_fail,
  // Timekeeping events and status
  input  wire logic                     update_in_progress,
  input  wire logic                     update_end_event,
  input  wire logic                     alarm_event,
  input  wire logic                     ram_valid,
  // Interrupt pin, open drain
  output wire logic                     irq_out,
  output wire logic                     irq_oe_n,
  // Square wave
  output logic                          square_wave_out,
  // Control bits for the timekeeper, and the bus access phase
  output logic [2:0]                    divider_ctrl,
  output logic [3:0]                    rate_select_field,
  output wire logic                     set_mode,
  output wire logic                     data_mode,
  output wire logic                     hour_24_mode,
  output wire logic                     dst_enable,
  output      rtc_port_pkg::bus_phase_type access_phase
);
  import rtc_port_pkg::*;

  strobe_if as_s ();
  strobe_if ds_s ();
  strobe_if rw_s ();
  strobe_if cs_s ();

  strobe_sync u_as_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .pin    (address_latch_strobe),
    .sp     (as_s)
  );

  strobe_sync u_ds_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .pin    (data_strobe_pin),
    .sp     (ds_s)
  );

  strobe_sync u_rw_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .pin    (rw_pin),
    .sp     (rw_s)
  );

  strobe_sync u_cs_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .pin    (chip_select_n),
    .sp     (cs_s)
  );

  bus_style_type style;
  byte_type      bus_d1;
  byte_type      bus_d2;
  byte_type      bus_d3;
  loc_type       addr;
  logic          addr_valid;
  logic          access_ok;
  logic          read_req;
  logic          write_req;
  logic          read_end;
  logic          write_end;
  logic          drive;
  logic          flag_read_done;
  byte_type      read_byte;
  byte_type      reg_b;
  logic          update_end_flag;
  logic          alarm_flag;
  logic          periodic_flag;
  logic          summary_int_flag;
  logic          periodic_int_enable;
  logic          alarm_int_enable;
  logic          update_end_int_enable;
  logic          square_wave_enable;
  logic [`OSC_DIV_W-1:0] prescale;
  logic          osc_tick;
  logic [`CHAIN_W-1:0]   chain;
  logic [3:0]    tap_idx;
  logic          tap;
  logic          tap_prev;
  logic          periodic_event;
  bus_phase_type next_phase;

  // General RAM plus clock bytes; no reset, so contents survive [RQ19]
  byte_type mem [0:`LOC_COUNT-1]; // [RQ22]

  assign style = bus_style_type'(bus_style_select); // [RQ1]

  // Delay line keeps bus data aligned with the synchronised strobes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_d1 <= `BYTE_ZERO;
      bus_d2 <= `BYTE_ZERO;
      bus_d3 <= `BYTE_ZERO;
    end else begin
      bus_d1 <= muxed_bus_lines_in;
      bus_d2 <= bus_d1;
      bus_d3 <= bus_d2;
    end
  end

  // Address latch; bus_d3 is the value seen just before the edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr       <= `LOC_SECONDS;
      addr_valid <= 1'b0;
    end else if (as_s.rise) begin
      addr_valid <= 1'b0; // [RQ3]
    end else if (as_s.fall) begin
      addr       <= bus_d3[6:0]; // [RQ2] [RQ4] [RQ11]
      addr_valid <= 1'b1;
    end
  end

  // Select gated by power fail and the reset pin
  assign access_ok = ~cs_s.level & ~power_fail & reset_pin_n; // [RQ13] [RQ18]

  always_comb begin
    if (style == STYLE_DATA_STROBE) begin
      read_req  = ds_s.level & rw_s.level; // [RQ9]
      write_req = ds_s.level & ~rw_s.level; // [RQ9]
      read_end  = ds_s.fall; // [RQ6]
      write_end = ds_s.fall; // [RQ8]
    end else begin
      read_req  = ~ds_s.level; // [RQ10]
      write_req = ~rw_s.level; // [RQ10]
      read_end  = ds_s.rise; // [RQ6]
      write_end = rw_s.rise;
    end
  end

  // Access phase tracking
  always_comb begin
    next_phase = access_phase;
    case (access_phase)
      PH_IDLE: begin
        if (addr_valid && access_ok && read_req) begin // [RQ11]
          next_phase = PH_READ;
        end else if (addr_valid && access_ok && write_req) begin
          next_phase = PH_WRITE;
        end
      end
      PH_READ: begin
        if (read_end || !access_ok) begin
          next_phase = PH_IDLE;
        end
      end
      PH_WRITE: begin
        if (write_end || !access_ok) begin
          next_phase = PH_IDLE;
        end
      end
      default: next_phase = PH_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      access_phase <= PH_IDLE;
    end else begin
      access_phase <= next_phase;
    end
  end

  // Flag byte clears once the read has finished [RQ26]
  assign flag_read_done = (access_phase == PH_READ) && read_end
                          && access_ok && (addr == `LOC_REG_C); // [RQ15]

  // Read mux
  always_comb begin
    case (addr)
      `LOC_REG_A: read_byte = {update_in_progress, divider_ctrl,
                               rate_select_field};
      `LOC_REG_B: read_byte = reg_b;
      `LOC_REG_C: read_byte = {summary_int_flag, periodic_flag,
                               alarm_flag, update_end_flag, 4'h0};
      `LOC_REG_D: read_byte = {ram_valid, 7'h00};
      default:    read_byte = mem[addr];
    endcase
  end

  // Data is refreshed each cycle of the read so it tracks the source
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      muxed_bus_lines_out <= `BYTE_ZERO;
    end else if (next_phase == PH_READ) begin
      muxed_bus_lines_out <= read_byte; // [RQ5]
    end
  end

  // Drive only inside the read, dropped on the closing edge
  assign drive = (access_phase == PH_READ) && read_req && access_ok
                 && !read_end; // [RQ5] [RQ6] [RQ10]
  assign muxed_bus_lines_oe_n = ~drive;

  // Byte store; flag and status bytes ignore writes
  always_ff @(posedge clk) begin
    if (access_phase == PH_WRITE && write_end && access_ok) begin // [RQ8]
      case (addr)
        `LOC_REG_A, `LOC_REG_B, `LOC_REG_C, `LOC_REG_D: begin // [RQ23]
        end
        `LOC_SECONDS: mem[addr] <= bus_d3 & `SEC_WR_MASK;
        default:      mem[addr] <= bus_d3;
      endcase
    end
  end

  // Byte A: rate select survives the reset pin
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      divider_ctrl      <= `DV_RST;
      rate_select_field <= `RS_RST;
    end else if (access_phase == PH_WRITE && write_end && access_ok
                 && addr == `LOC_REG_A) begin
      divider_ctrl      <= bus_d3[`A_DV_HI:`A_DV_LO];
      rate_select_field <= bus_d3[`A_RS_HI:`A_RS_LO]; // [RQ24]
    end
  end

  // Byte B; the reset pin clears only the enables
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_b <= `REG_B_RST;
    end else if (!reset_pin_n) begin
      reg_b[`B_PIE]  <= 1'b0; // [RQ16]
      reg_b[`B_AIE]  <= 1'b0; // [RQ16]
      reg_b[`B_UIE]  <= 1'b0; // [RQ16]
      reg_b[`B_SQUARE_WAVE_ENABLE] <= 1'b0; // [RQ16]
    end else if (access_phase == PH_WRITE && write_end && access_ok
                 && addr == `LOC_REG_B) begin
      reg_b <= bus_d3;
    end
  end

  assign periodic_int_enable   = reg_b[`B_PIE];
  assign alarm_int_enable      = reg_b[`B_AIE];
  assign update_end_int_enable = reg_b[`B_UIE];
  assign square_wave_enable    = reg_b[`B_SQUARE_WAVE_ENABLE];
  assign set_mode              = reg_b[`B_SET];
  assign data_mode             = reg_b[`B_DM];
  assign hour_24_mode          = reg_b[`B_HR24];
  assign dst_enable            = reg_b[`B_DSE];

  // Flags: reset pin wins, otherwise a new event beats the read clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      update_end_flag <= 1'b0;
      alarm_flag      <= 1'b0;
      periodic_flag   <= 1'b0;
    end else if (!reset_pin_n) begin
      update_end_flag <= 1'b0; // [RQ17]
      alarm_flag      <= 1'b0; // [RQ17]
      periodic_flag   <= 1'b0; // [RQ17]
    end else begin
      update_end_flag <= update_end_event
                         | (update_end_flag & ~flag_read_done); // [RQ15]
      alarm_flag      <= alarm_event
                         | (alarm_flag & ~flag_read_done); // [RQ15]
      periodic_flag   <= periodic_event
                         | (periodic_flag & ~flag_read_done); // [RQ15]
    end
  end

  assign summary_int_flag = (periodic_flag & periodic_int_enable)
                          | (alarm_flag & alarm_int_enable)
                          | (update_end_flag & update_end_int_enable);

  // Open drain: pull low while a summary request stands
  assign irq_out  = 1'b0;
  assign irq_oe_n = ~summary_int_flag; // [RQ14] [RQ17]

  // Oscillator stand-in: one tick per nominal oscillator period
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prescale <= '0;
    end else if (prescale == `OSC_DIV_W'(`OSC_DIV_CYCLES - 1)) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + `OSC_DIV_W'(1);
    end
  end

  assign osc_tick = (prescale == `OSC_DIV_W'(`OSC_DIV_CYCLES - 1));

  // Divider chain; held clear while the chain-reset pattern is set
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chain <= '0;
    end else if (divider_ctrl[2:1] == `DV_CHAIN_HOLD) begin
      chain <= '0;
    end else if (osc_tick && divider_ctrl == `DV_RUN) begin
      chain <= chain + `CHAIN_W'(1);
    end
  end

  // Tap choice: codes 1 and 2 reuse the taps of codes 8 and 9 [RQ21]
  always_comb begin
    case (rate_select_field)
      `RS_TAP_1: tap_idx = `TAP_IDX_1;
      `RS_TAP_2: tap_idx = `TAP_IDX_2;
      default:   tap_idx = rate_select_field - `TAP_IDX_OFFSET;
    endcase
  end

  assign tap = (rate_select_field != `RS_OFF) && chain[tap_idx]; // [RQ21]

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tap_prev <= 1'b0;
    end else begin
      tap_prev <= tap;
    end
  end

  assign periodic_event = tap & ~tap_prev;

  // Square wave gated by enable; dead under power fail
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      square_wave_out <= 1'b0;
    end else begin
      square_wave_out <= tap & square_wave_enable & ~power_fail; // [RQ21]
    end
  end

endmodule : rtc_muxed_host_bus_port

/* File: rtc_port_checker_sva.sv */
`timescale 1ns/1ps
module rtc_port_checker (
  // Clock and reset
  input wire logic                        clk,
  input wire logic                        arst_n,
  // Host bus
  input wire logic                        bus_style_select,
  input wire logic                        data_strobe_pin,
  input wire logic                        chip_select_n,
  input wire logic                        muxed_bus_lines_oe_n,
  input wire rtc_port_pkg::bus_phase_type access_phase,
  // Device state
  input wire logic                        reset_pin_n,
  input wire logic                        power_fail,
  input wire logic                        irq_oe_n
);
  import rtc_port_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_ds_end;
    bus_style_select && $fell(data_strobe_pin);
  endsequence
  sequence s_rd_end;
    !bus_style_select && $rose(data_strobe_pin);
  endsequence
  property p_drive_in_read;
    !muxed_bus_lines_oe_n |->
      access_phase == PH_READ && !power_fail && reset_pin_n;
  endproperty
  a_drive_in_read: assert property (p_drive_in_read)
    else $error("bus driven outside a read");
  property p_ds_release;
    s_ds_end |-> ##[1:4] muxed_bus_lines_oe_n;
  endproperty
  a_ds_release: assert property (p_ds_release)
    else $error("bus held after data strobe fell");
  property p_rd_release;
    s_rd_end |-> ##[1:4] muxed_bus_lines_oe_n;
  endproperty
  a_rd_release: assert property (p_rd_release)
    else $error("bus held after read strobe rose");
  property p_drive_after_strobe;
    $fell(muxed_bus_lines_oe_n) |->
      $past(bus_style_select ? data_strobe_pin : !data_strobe_pin, 2);
  endproperty
  a_drive_after_strobe: assert property (p_drive_after_strobe)
    else $error("drive began before synchronised strobe");
  property p_no_select;
    chip_select_n [*5] |-> access_phase == PH_IDLE;
  endproperty
  a_no_select: assert property (p_no_select)
    else $error("access without chip select");
  property p_power_fail;
    power_fail [*5] |-> access_phase == PH_IDLE;
  endproperty
  a_power_fail: assert property (p_power_fail)
    else $error("access during power fail");
  property p_reset_blocks;
    !reset_pin_n [*4] |-> access_phase == PH_IDLE && irq_oe_n;
  endproperty
  a_reset_blocks: assert property (p_reset_blocks)
    else $error("access or interrupt while reset pin low");
  property p_irq_needs_reset_high;
    $fell(irq_oe_n) |-> $past(reset_pin_n);
  endproperty
  a_irq_needs_reset_high: assert property (p_irq_needs_reset_high)
    else $error("interrupt pulled while reset pin low");
endmodule : rtc_port_checker

bind rtc_muxed_host_bus_port rtc_port_checker u_chk (
  .clk(clk), .arst_n(arst_n), .bus_style_select(bus_style_select),
  .data_strobe_pin(data_strobe_pin), .chip_select_n(chip_select_n),
  .muxed_bus_lines_oe_n(muxed_bus_lines_oe_n), .access_phase(access_phase),
  .reset_pin_n(reset_pin_n), .power_fail(power_fail), .irq_oe_n(irq_oe_n)
);

/* File: rtc_host_model.sv */
`timescale 1ns/1ps
module rtc_host_model (
  // Clock and style
  input  wire logic                   clk,
  input  wire logic                   bus_style_select,
  // Strobes toward the device
  output logic                        address_latch_strobe,
  output logic                        data_strobe_pin,
  output logic                        rw_pin,
  output logic                        chip_select_n,
  // Bus lines
  output rtc_port_pkg::byte_type      bus_in,
  input  wire rtc_port_pkg::byte_type bus_out,
  input  wire logic                   bus_oe_n
);
  import rtc_port_pkg::*;
  byte_type drv;
  // Released bus shows the inverse of the last value, never a stale copy
  assign bus_in = !bus_oe_n ? bus_out : drv;
  initial begin
    drv = 8'h00;
    address_latch_strobe = 1'b0;
    data_strobe_pin = 1'b0;
    rw_pin = 1'b1;
    chip_select_n = 1'b1;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step
  task automatic xfer(input logic wr, input logic sel, input loc_type loc,
                      input byte_type wdata, output byte_type rdata);
    step(1);
    data_strobe_pin = !bus_style_select;
    chip_select_n = !sel;
    drv = {1'b0, loc};
    address_latch_strobe = 1'b1;
    step(6);
    address_latch_strobe = 1'b0;
    step(4);
    drv = wr ? wdata : ~drv;
    if (bus_style_select) begin
      rw_pin = !wr;
      data_strobe_pin = 1'b1;
    end else if (wr) begin
      rw_pin = 1'b0;
    end else begin
      data_strobe_pin = 1'b0;
    end
    step(8);
    rdata = bus_in;
    data_strobe_pin = !bus_style_select;
    rw_pin = 1'b1;
    step(4);
    drv = ~drv;
    chip_select_n = 1'b1;
    step(3);
  endtask : xfer
endmodule : rtc_host_model

/* File: rtc_muxed_host_bus_port_bench.sv */
`timescale 1ns/1ps
`include "rtc_port_params.svh"
module rtc_muxed_host_bus_port_bench;
  import rtc_port_pkg::*;
  logic          clk, arst_n, bus_style_select, reset_pin_n, power_fail;
  logic          update_in_progress, update_end_event, alarm_event;
  logic          ram_valid, address_latch_strobe, data_strobe_pin, rw_pin;
  logic          chip_select_n, oe_n, irq_out, irq_oe_n, square_wave_out, t;
  logic          set_mode, data_mode, hour_24_mode, dst_enable;
  byte_type      bus_in, bus_out, q;
  logic [2:0]    divider_ctrl;
  logic [3:0]    rate_select_field;
  bus_phase_type access_phase;
  int            error_cnt, samples_checked, n;
  rtc_host_model host (
    .clk(clk), .bus_style_select(bus_style_select),
    .address_latch_strobe(address_latch_strobe),
    .data_strobe_pin(data_strobe_pin), .rw_pin(rw_pin),
    .chip_select_n(chip_select_n), .bus_in(bus_in), .bus_out(bus_out),
    .bus_oe_n(oe_n)
  );
  rtc_muxed_host_bus_port dut (
    .clk(clk), .arst_n(arst_n), .bus_style_select(bus_style_select),
    .address_latch_strobe(address_latch_strobe),
    .data_strobe_pin(data_strobe_pin), .rw_pin(rw_pin),
    .chip_select_n(chip_select_n), .muxed_bus_lines_in(bus_in),
    .muxed_bus_lines_out(bus_out), .muxed_bus_lines_oe_n(oe_n),
    .reset_pin_n(reset_pin_n), .power_fail(power_fail),
    .update_in_progress(update_in_progress),
    .update_end_event(update_end_event), .alarm_event(alarm_event),
    .ram_valid(ram_valid), .irq_out(irq_out), .irq_oe_n(irq_oe_n),
    .square_wave_out(square_wave_out), .divider_ctrl(divider_ctrl),
    .rate_select_field(rate_select_field), .set_mode(set_mode),
    .data_mode(data_mode), .hour_24_mode(hour_24_mode),
    .dst_enable(dst_enable), .access_phase(access_phase)
  );
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input string what, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input loc_type a, input byte_type d);
    host.xfer(1'b1, 1'b1, a, d, q);
  endtask : wr
  task automatic rd(input loc_type a);
    host.xfer(1'b0, 1'b1, a, 8'h00, q);
  endtask : rd
  task automatic pulse_update();
    @(posedge clk);
    #2 update_end_event = 1'b1;
    @(posedge clk);
    #2 update_end_event = 1'b0;
    host.step(3);
  endtask : pulse_update
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  initial begin
    {arst_n, bus_style_select, power_fail, update_in_progress} = 4'h0;
    {update_end_event, alarm_event, reset_pin_n, ram_valid} = 4'h3;
    error_cnt = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk);
    #2 arst_n = 1'b1;
    check("oe_n", {7'h0, oe_n}, 8'h01);
    for (int s = 0; s < 2; s++) begin
      bus_style_select = s[0];
      wr(7'(32 + s), 8'(90 + s));
      host.xfer(1'b1, 1'b0, 7'(32 + s), 8'hFF, q);
      power_fail = 1'b1;
      wr(7'(32 + s), 8'hEE);
      power_fail = 1'b0;
      wr(`LOC_CENTURY, 8'(20 + s));
      rd(7'(32 + s));
      check("ram", q, 8'(90 + s));
      rd(`LOC_CENTURY);
      check("century", q, 8'(20 + s));
    end
    wr(`LOC_REG_C, 8'hFF);
    rd(`LOC_REG_C);
    check("flags", q, 8'h00);
    rd(`LOC_REG_D);
    check("status", {7'h0, q[7]}, 8'h01);
    wr(`LOC_REG_A, 8'h23);
    check("rate", {4'h0, rate_select_field}, 8'h03);
    check("divider", {5'h0, divider_ctrl}, 8'h02);
    wr(`LOC_REG_B, 8'h1E);
    pulse_update();
    check("irq", {7'h0, irq_oe_n}, 8'h00);
    check("irq_data", {7'h0, irq_out}, 8'h00);
    rd(`LOC_REG_C);
    check("flags", q & 8'hB0, 8'h90);
    check("irq", {7'h0, irq_oe_n}, 8'h01);
    t = square_wave_out;
    n = 0;
    while (square_wave_out === t && n < 3000) begin
      host.step(1);
      n++;
    end
    check("square", {7'h0, n < 3000}, 8'h01);
    pulse_update();
    reset_pin_n = 1'b0;
    wr(7'd32, 8'h00);
    check("irq", {7'h0, irq_oe_n}, 8'h01);
    reset_pin_n = 1'b1;
    rd(`LOC_REG_B);
    check("enables", q, 8'h06);
    check("modes", {4'h0, set_mode, data_mode, hour_24_mode, dst_enable},
          8'h06);
    check("square_off", {7'h0, square_wave_out}, 8'h00);
    rd(`LOC_REG_C);
    check("flags", q & 8'hB0, 8'h00);
    check("rate", {4'h0, rate_select_field}, 8'h03);
    rd(7'd32);
    check("ram", q, 8'd90);
    complete_run();
  end
  // Limit covers all accesses plus one square-wave half period
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    complete_run();
  end
endmodule : rtc_muxed_host_bus_port_bench
